//--- pkg/watch_timer_pkg.sv
package watch_timer_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // clock and times
   localparam int unsigned CLK_PERIOD_NS   = 10;
   localparam int unsigned IVL_HS_NS       = 1995000;
   localparam int unsigned IVL_125MS_NS    = 125000000;
   localparam int unsigned IVL_250MS_NS    = 250000000;
   localparam int unsigned IVL_500MS_NS    = 500000000;
   // half periods of the buzzer tones
   localparam int unsigned BUZ_500HZ_HALF_NS = 1000000;
   localparam int unsigned BUZ_1KHZ_HALF_NS  = 500000;
   localparam int unsigned BUZ_2KHZ_HALF_NS  = 250000;
   localparam int unsigned BUZ_4KHZ_HALF_NS  = 125000;

   ////////////////////////////////////////////////////////////////////////////////
   // divider width, enough for the longest interval in cycles
   localparam int unsigned DIV_W = 26;

   ////////////////////////////////////////////////////////////////////////////////
   // control register location and layout
   localparam logic [7:0] CTL_ADDR     = 8'hfe;
   localparam logic       CTL_SET      = 1'b1;
   localparam logic       CTL_BANK     = 1'b1;
   localparam logic [7:0] CTL_RESET    = 8'h00;
   localparam int unsigned BIT_PENDING = 0;
   localparam int unsigned BIT_ENABLE  = 1;
   localparam int unsigned SEL_LO      = 2;
   localparam int unsigned BUZ_LO      = 4;
   localparam int unsigned BIT_IRQ_EN  = 6;
   localparam int unsigned CTL_USED_W  = 7;
   localparam logic [7:0] IRQ_VECTOR   = 8'he2;

   typedef enum logic [1:0] {
      IVL_500MS = 2'h0,
      IVL_250MS = 2'h1,
      IVL_125MS = 2'h2,
      IVL_HS    = 2'h3
   } interval_sel_t;

   typedef enum logic [1:0] {
      BUZ_500HZ = 2'h0,
      BUZ_1KHZ  = 2'h1,
      BUZ_2KHZ  = 2'h2,
      BUZ_4KHZ  = 2'h3
   } buzzer_sel_t;

   // field order matches the register bit positions, bit 7 reserved
   typedef struct packed {
      logic          overflow_irq_enable;
      buzzer_sel_t   buzzer_select;
      interval_sel_t interval_select;
      logic          watch_enable;
      logic          interval_pending;
   } watch_timer_control_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic       reg_set;
      logic       bank;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      watch_timer_control_t ctl;
      logic [7:0]           rdata;
      logic                 irq;
      logic [7:0]           vector;
      logic                 buzzer;
   } watch_state_t;

   typedef struct packed {
      logic [DIV_W-1:0] cnt;
      logic             tick;
   } div_state_t;

endpackage

//--- core/period_divider.sv
`timescale 1ns/1ns
`default_nettype none

module period_divider (
   input  wire logic                                clk_sys_in, // system clock
   input  wire logic                                rst_b_in,   // sync reset, active low
   input  wire logic                                ce_in,      // clock enable
   input  wire logic                                run_in,     // count while high
   input  wire logic [watch_timer_pkg::DIV_W-1:0]   limit_in,   // cycles per tick
   output logic                                     tick_out    // one-cycle pulse per period
);

   watch_timer_pkg::div_state_t s;
   watch_timer_pkg::div_state_t next_s;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_s      = s;
      next_s.tick = 1'b0;
      if (!run_in) begin
         next_s.cnt = '0;
      end else if (s.cnt >= limit_in - watch_timer_pkg::DIV_W'(1)) begin
         // >= so a shorter limit chosen mid-period wraps at once
         next_s.cnt  = '0;
         next_s.tick = 1'b1;
      end else begin
         next_s.cnt = s.cnt + watch_timer_pkg::DIV_W'(1);
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         s <= '0;
      end else if (ce_in) begin
         s <= next_s;
      end
   end

   assign tick_out = s.tick;

   ////////////////////////////////////////////////////////////////////////////////
   property p_idle_cleared;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (ce_in && !run_in) |=> (s.cnt == '0 && !s.tick);
   endproperty
   a_idle_cleared: assert property (p_idle_cleared) else $error("divider not cleared while stopped");

   property p_wrap_tick;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (ce_in && run_in && s.cnt >= limit_in - watch_timer_pkg::DIV_W'(1)) |=> (s.tick && s.cnt == '0);
   endproperty
   a_wrap_tick: assert property (p_wrap_tick) else $error("divider missed its period end");

endmodule

`default_nettype wire

//--- core/watch_interval_timer.sv
`timescale 1ns/1ns
`default_nettype none

module watch_interval_timer #(
   parameter int unsigned IVL_HS_CYC    = watch_timer_pkg::IVL_HS_NS / watch_timer_pkg::CLK_PERIOD_NS,
   parameter int unsigned IVL_125MS_CYC = watch_timer_pkg::IVL_125MS_NS / watch_timer_pkg::CLK_PERIOD_NS,
   parameter int unsigned IVL_250MS_CYC = watch_timer_pkg::IVL_250MS_NS / watch_timer_pkg::CLK_PERIOD_NS,
   parameter int unsigned IVL_500MS_CYC = watch_timer_pkg::IVL_500MS_NS / watch_timer_pkg::CLK_PERIOD_NS,
   parameter int unsigned BUZ_500HZ_CYC = watch_timer_pkg::BUZ_500HZ_HALF_NS / watch_timer_pkg::CLK_PERIOD_NS,
   parameter int unsigned BUZ_1KHZ_CYC  = watch_timer_pkg::BUZ_1KHZ_HALF_NS / watch_timer_pkg::CLK_PERIOD_NS,
   parameter int unsigned BUZ_2KHZ_CYC  = watch_timer_pkg::BUZ_2KHZ_HALF_NS / watch_timer_pkg::CLK_PERIOD_NS,
   parameter int unsigned BUZ_4KHZ_CYC  = watch_timer_pkg::BUZ_4KHZ_HALF_NS / watch_timer_pkg::CLK_PERIOD_NS
) (
   input  wire logic                       clk_sys_in,                // main system clock
   input  wire logic                       rst_b_in,                  // sync reset, active low
   input  wire logic                       ce_in,                     // clock enable, freezes all state
   input  wire watch_timer_pkg::reg_req_t  reg_req_in,                // register access from the core
   output logic [7:0]                      reg_rdata_out,             // read data, one cycle after rd
   output logic                            interrupt_level_four_out,  // overflow request, level
   output logic [7:0]                      irq_vector_out,            // vector of the overflow request
   output logic                            buzzer_output_out          // buzzer square wave pin
);

   ////////////////////////////////////////////////////////////////////////////////
   // state
   watch_timer_pkg::watch_state_t s;
   watch_timer_pkg::watch_state_t next_s;

   logic                              ctl_hit;
   logic                              ctl_wr;
   logic                              ctl_rd;
   logic [7:0]                        ctl_image;
   logic [watch_timer_pkg::DIV_W-1:0] interval_limit;
   logic [watch_timer_pkg::DIV_W-1:0] buzzer_limit;
   logic                              interval_tick;
   logic                              buzzer_tick;

   ////////////////////////////////////////////////////////////////////////////////
   // register decode
   always_comb begin
      ctl_hit = reg_req_in.reg_set == watch_timer_pkg::CTL_SET
             && reg_req_in.bank == watch_timer_pkg::CTL_BANK
             && reg_req_in.addr == watch_timer_pkg::CTL_ADDR;
      ctl_wr    = reg_req_in.wr && ctl_hit;
      ctl_rd    = reg_req_in.rd && ctl_hit;
      ctl_image = 8'(s.ctl); // reserved bit 7 reads zero
   end

   ////////////////////////////////////////////////////////////////////////////////
   // period selection
   always_comb begin
      unique case (s.ctl.interval_select)
         watch_timer_pkg::IVL_500MS : interval_limit = watch_timer_pkg::DIV_W'(IVL_500MS_CYC);
         watch_timer_pkg::IVL_250MS : interval_limit = watch_timer_pkg::DIV_W'(IVL_250MS_CYC);
         watch_timer_pkg::IVL_125MS : interval_limit = watch_timer_pkg::DIV_W'(IVL_125MS_CYC);
         watch_timer_pkg::IVL_HS    : interval_limit = watch_timer_pkg::DIV_W'(IVL_HS_CYC);
      endcase
      unique case (s.ctl.buzzer_select)
         watch_timer_pkg::BUZ_500HZ : buzzer_limit = watch_timer_pkg::DIV_W'(BUZ_500HZ_CYC);
         watch_timer_pkg::BUZ_1KHZ  : buzzer_limit = watch_timer_pkg::DIV_W'(BUZ_1KHZ_CYC);
         watch_timer_pkg::BUZ_2KHZ  : buzzer_limit = watch_timer_pkg::DIV_W'(BUZ_2KHZ_CYC);
         watch_timer_pkg::BUZ_4KHZ  : buzzer_limit = watch_timer_pkg::DIV_W'(BUZ_4KHZ_CYC);
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // dividers straight off the system clock, no slow oscillator needed
   period_divider u_interval (
      .clk_sys_in (clk_sys_in),
      .rst_b_in   (rst_b_in),
      .ce_in      (ce_in),
      .run_in     (s.ctl.watch_enable),
      .limit_in   (interval_limit),
      .tick_out   (interval_tick)
   );

   period_divider u_buzzer (
      .clk_sys_in (clk_sys_in),
      .rst_b_in   (rst_b_in),
      .ce_in      (ce_in),
      .run_in     (s.ctl.watch_enable),
      .limit_in   (buzzer_limit),
      .tick_out   (buzzer_tick)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      next_s = s;
      if (ctl_wr) begin
         next_s.ctl.watch_enable        = reg_req_in.wdata[watch_timer_pkg::BIT_ENABLE];
         next_s.ctl.overflow_irq_enable = reg_req_in.wdata[watch_timer_pkg::BIT_IRQ_EN];
         next_s.ctl.interval_select     =
            watch_timer_pkg::interval_sel_t'(reg_req_in.wdata[watch_timer_pkg::SEL_LO +: 2]);
         next_s.ctl.buzzer_select       =
            watch_timer_pkg::buzzer_sel_t'(reg_req_in.wdata[watch_timer_pkg::BUZ_LO +: 2]);
         // writing one leaves pending as it is, software cannot fake an overflow
         next_s.ctl.interval_pending    =
            s.ctl.interval_pending & reg_req_in.wdata[watch_timer_pkg::BIT_PENDING];
      end
      // an overflow in the clearing cycle wins, so no period is lost
      if (interval_tick) begin
         next_s.ctl.interval_pending = 1'b1;
      end
      next_s.rdata  = ctl_rd ? ctl_image : 8'h00;
      next_s.irq    = s.ctl.interval_pending & s.ctl.overflow_irq_enable;
      next_s.vector = watch_timer_pkg::IRQ_VECTOR;
      if (!s.ctl.watch_enable) begin
         next_s.buzzer = 1'b0;
      end else if (buzzer_tick) begin
         next_s.buzzer = ~s.buzzer;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         s     <= '0;
         s.ctl <= watch_timer_pkg::watch_timer_control_t'(
                     watch_timer_pkg::CTL_RESET[watch_timer_pkg::CTL_USED_W-1:0]);
      end else if (ce_in) begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs
   assign reg_rdata_out            = s.rdata;
   assign interrupt_level_four_out = s.irq;
   assign irq_vector_out           = s.vector;
   assign buzzer_output_out        = s.buzzer;

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   sequence q_clear_write;
      ce_in && ctl_wr && !reg_req_in.wdata[watch_timer_pkg::BIT_PENDING] && !interval_tick;
   endsequence

   sequence q_pending_gone;
      !s.ctl.interval_pending ##1 !interrupt_level_four_out;
   endsequence

   property p_idle_no_tick;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (ce_in && !s.ctl.watch_enable) |=> !interval_tick;
   endproperty
   a_idle_no_tick: assert property (p_idle_no_tick) else $error("interval tick while disabled");

   property p_irq_gate;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      ce_in |=> (interrupt_level_four_out == ($past(s.ctl.interval_pending) && $past(s.ctl.overflow_irq_enable)));
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("request does not follow pending and enable");

   property p_tick_sets;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (ce_in && interval_tick) |=> s.ctl.interval_pending;
   endproperty
   a_tick_sets: assert property (p_tick_sets) else $error("overflow did not set pending");

   property p_clear;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      q_clear_write ##1 ce_in |-> q_pending_gone;
   endproperty
   a_clear: assert property (p_clear) else $error("pending or request survived a clear");

   property p_hs_limit;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (s.ctl.interval_select == watch_timer_pkg::IVL_HS)
         |-> (interval_limit == watch_timer_pkg::DIV_W'(IVL_HS_CYC));
   endproperty
   a_hs_limit: assert property (p_hs_limit) else $error("high-speed period wrong");

   property p_buzzer_toggle;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (ce_in && s.ctl.watch_enable && buzzer_tick) |=> (buzzer_output_out != $past(buzzer_output_out));
   endproperty
   a_buzzer_toggle: assert property (p_buzzer_toggle) else $error("buzzer missed a toggle");

   property p_reset_value;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      $rose(rst_b_in) |-> (ctl_image == watch_timer_pkg::CTL_RESET && !interrupt_level_four_out);
   endproperty
   a_reset_value: assert property (p_reset_value) else $error("control not cleared by reset");

   property p_vector;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (ce_in && $past(rst_b_in)) |=> (irq_vector_out == watch_timer_pkg::IRQ_VECTOR);
   endproperty
   a_vector: assert property (p_vector) else $error("vector wrong");

   property p_read_back;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (ce_in && ctl_rd) |=> (reg_rdata_out == $past(ctl_image));
   endproperty
   a_read_back: assert property (p_read_back) else $error("read data differs from control");

   property p_freeze;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      !ce_in |=> $stable(s);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");

endmodule

`default_nettype wire

//--- verification/test_watch_interval_timer.sv
`timescale 1ns/1ns
`default_nettype none

module test_watch_interval_timer;

   ////////////////////////////////////////////////////////////////////////////////
   // shortened periods so every select value fits a short run
   localparam int unsigned HS = 20, P125 = 40, P250 = 60, P500 = 80;
   localparam int unsigned B500 = 10, B1K = 8, B2K = 6, B4K = 4;
   localparam int unsigned LIMIT = 6000;

   logic                       clk_sys_in = 1'b0;
   logic                       rst_b_in   = 1'b0;
   logic                       ce_in      = 1'b1;
   watch_timer_pkg::reg_req_t  req        = '0;
   wire logic [7:0]            reg_rdata_out;
   wire logic                  irq_out;
   wire logic [7:0]            vector_out;
   wire logic                  buzzer_out;
   int                         failures = 0;
   int                         samples_checked = 0;
   int                         cyc = 0;
   // enable edge to request: n count edges, one to pending, one to the request
   int                         offset = 2;

   watch_interval_timer #(
      .IVL_HS_CYC(HS), .IVL_125MS_CYC(P125), .IVL_250MS_CYC(P250), .IVL_500MS_CYC(P500),
      .BUZ_500HZ_CYC(B500), .BUZ_1KHZ_CYC(B1K), .BUZ_2KHZ_CYC(B2K), .BUZ_4KHZ_CYC(B4K)
   ) i_dut (
      .clk_sys_in               (clk_sys_in),
      .rst_b_in                 (rst_b_in),
      .ce_in                    (ce_in),
      .reg_req_in               (req),
      .reg_rdata_out            (reg_rdata_out),
      .interrupt_level_four_out (irq_out),
      .irq_vector_out           (vector_out),
      .buzzer_output_out        (buzzer_out)
   );

   always #5 clk_sys_in = ~clk_sys_in;

   always @(posedge clk_sys_in) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         failures++;
         stop_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one-cycle strobe; rdata is settled just after the edge that ends it
   task automatic bus(input logic wr, input logic [7:0] addr, input logic [7:0] wdata, input logic hit_set);
      @(posedge clk_sys_in);
      req.wr      <= wr;
      req.rd      <= !wr;
      req.reg_set <= hit_set;
      req.bank    <= 1'b1;
      req.addr    <= addr;
      req.wdata   <= wdata;
      @(posedge clk_sys_in);
      req.wr <= 1'b0;
      req.rd <= 1'b0;
      #1;
   endtask

   task automatic wait_irq();
      int n;
      n = 0;
      do begin
         @(posedge clk_sys_in);
         #1;
         n++;
      end while (irq_out !== 1'b1 && n < 1000);
   endtask

   task automatic wait_buz_edge(output int n);
      logic last;
      last = buzzer_out;
      n = 0;
      do begin
         @(posedge clk_sys_in);
         #1;
         n++;
      end while (buzzer_out === last && n < 1000);
   endtask

   function automatic int unsigned period(input logic [1:0] sel);
      case (sel)
         2'h0: return P500;
         2'h1: return P250;
         2'h2: return P125;
         default: return HS;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_registers();
      bus(1'b0, 8'hfe, 8'h00, 1'b1);
      check(reg_rdata_out, 8'h00);
      check(vector_out, 8'he2);
      bus(1'b1, 8'hfe, 8'hf3, 1'b1);
      bus(1'b0, 8'hfe, 8'h00, 1'b1);
      check(reg_rdata_out, 8'h72);
      bus(1'b1, 8'hfd, 8'h00, 1'b1);
      bus(1'b1, 8'hfe, 8'h00, 1'b0);
      bus(1'b0, 8'hfe, 8'h00, 1'b1);
      check(reg_rdata_out, 8'h72);
      bus(1'b0, 8'hfd, 8'h00, 1'b1);
      check(reg_rdata_out, 8'h00);
      bus(1'b1, 8'hfe, 8'h00, 1'b1);
      $display("test_registers done");
   endtask

   task automatic test_intervals();
      int t0, t1;
      for (int s = 3; s >= 0; s--) begin
         bus(1'b1, 8'hfe, 8'h00, 1'b1);
         bus(1'b1, 8'hfe, 8'h42 | (s[7:0] << 2), 1'b1);
         t0 = cyc;
         wait_irq();
         check(cyc - t0 - period(s[1:0]), offset);
         t1 = cyc;
         bus(1'b1, 8'hfe, 8'h42 | (s[7:0] << 2), 1'b1);
         wait_irq();
         check(cyc - t1, period(s[1:0]));
      end
      bus(1'b1, 8'hfe, 8'h00, 1'b1);
      $display("test_intervals done");
   endtask

   task automatic test_irq_gate();
      bus(1'b1, 8'hfe, 8'h0e, 1'b1);
      repeat (HS + offset + 4) begin
         @(posedge clk_sys_in);
         #1;
         check(irq_out, 1'b0);
      end
      bus(1'b0, 8'hfe, 8'h00, 1'b1);
      check(reg_rdata_out, 8'h0f);
      bus(1'b1, 8'hfe, 8'h4f, 1'b1);
      @(posedge clk_sys_in);
      #1;
      check(irq_out, 1'b1);
      bus(1'b1, 8'hfe, 8'h4e, 1'b1);
      @(posedge clk_sys_in);
      #1;
      check(irq_out, 1'b0);
      bus(1'b0, 8'hfe, 8'h00, 1'b1);
      check(reg_rdata_out, 8'h4e);
      bus(1'b1, 8'hfe, 8'h00, 1'b1);
      $display("test_irq_gate done");
   endtask

   task automatic test_buzzer();
      int n;
      int unsigned half [4] = '{B500, B1K, B2K, B4K};
      for (int b = 0; b < 4; b++) begin
         bus(1'b1, 8'hfe, 8'h02 | (b[7:0] << 4), 1'b1);
         wait_buz_edge(n);
         wait_buz_edge(n);
         check(n, half[b]);
         wait_buz_edge(n);
         check(n, half[b]);
      end
      bus(1'b1, 8'hfe, 8'h00, 1'b1);
      @(posedge clk_sys_in);
      #1;
      check(buzzer_out, 1'b0);
      $display("test_buzzer done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20) @(posedge clk_sys_in);
      rst_b_in <= 1'b1;
      test_registers();
      test_intervals();
      test_irq_gate();
      test_buzzer();
      stop_test();
   end

endmodule

`default_nettype wire
